/* File: logic/sdc_pkg.sv */
/*
 * Shared constants and state types for the single-wire debug controller.
 * Assumes the controller clock is also the serial communication clock.
 */
package sdc_pkg;

	// Bit-time timing, in controller clock cycles from perceived bit start
	localparam logic [9:0] BIT_CYC = 10'h010;
	localparam logic [9:0] SAMPLE_CYC = 10'h00a;
	localparam logic [9:0] ONE_SPEEDUP_CYC = 10'h007;
	localparam logic [9:0] ZERO_LOW_CYC = 10'h00d;
	localparam logic [9:0] TIMEOUT_CYC = 10'h200;
	localparam logic [9:0] SYNC_MIN_LOW_CYC = 10'h080;
	localparam logic [9:0] SYNC_DELAY_CYC = 10'h010;
	localparam logic [9:0] SYNC_PULSE_CYC = 10'h080;
	localparam logic [9:0] CNT_MAX = 10'h3ff;

	// Command codes
	localparam logic [7:0] CMD_BACKGROUND = 8'h90;
	localparam logic [7:0] CMD_ACK_ON = 8'hd5;
	localparam logic [7:0] CMD_ACK_OFF = 8'hd6;
	localparam logic [7:0] CMD_READ_STATUS = 8'he4;
	localparam logic [7:0] CMD_WRITE_CONTROL = 8'hc4;
	localparam logic [7:0] CMD_READ_BYTE = 8'he0;
	localparam logic [7:0] CMD_READ_BYTE_WS = 8'he1;
	localparam logic [7:0] CMD_READ_LAST = 8'he8;
	localparam logic [7:0] CMD_WRITE_BYTE = 8'hc0;
	localparam logic [7:0] CMD_WRITE_BYTE_WS = 8'hc1;
	localparam logic [7:0] CMD_READ_BKPT = 8'he2;
	localparam logic [7:0] CMD_WRITE_BKPT = 8'hc2;
	localparam logic [7:0] CMD_GO = 8'h08;
	localparam logic [7:0] CMD_SINGLE_STEP = 8'h10;
	localparam logic [7:0] CMD_TAGGO = 8'h18;
	// CPU register access: low three bits select the register
	localparam logic [4:0] CMD_READ_REG_HI = 5'h0c;
	localparam logic [4:0] CMD_WRITE_REG_HI = 5'h08;

	// Status and control byte
	localparam int ST_ENABLE_POS = 7;
	localparam int ST_HALTED_POS = 6;
	localparam int ST_BKPT_EN_POS = 5;
	localparam logic [4:0] ST_LOW_ZERO = 5'h00;
	localparam logic BKPT_EN_RST = 1'b0;
	localparam logic [15:0] BKPT_ADDR_RST = 16'h0000;

	localparam logic [4:0] LEN_BYTE = 5'h08;
	localparam logic [4:0] LEN_WORD = 5'h10;

	typedef enum logic [2:0] {
		PIN_IDLE = 3'b000,
		PIN_BIT = 3'b001,
		PIN_SYNC_LOW = 3'b010,
		PIN_SYNC_DLY = 3'b011,
		PIN_SYNC_DRV = 3'b100,
		PIN_SYNC_SPD = 3'b101
	} sdc_pin_state_t;

	typedef enum logic [2:0] {
		CS_CMD = 3'b000,
		CS_ADDR = 3'b001,
		CS_DATA = 3'b010,
		CS_ACC = 3'b011,
		CS_TX = 3'b100
	} sdc_cmd_state_t;

endpackage : sdc_pkg

/* File: logic/sdc_pin_engine.sv */
/*
 * Bit-level engine for the debug pin: synchroniser, bit timing, sampling,
 * device-side drive with speed-up pulses, sync response and timeout.
 * Assumes the pin wire is resolved outside from pin_out and pin_oe.
 */
`timescale 1ns/1ns
`default_nettype none

module sdc_pin_engine
	import sdc_pkg::*;
(
	input wire logic clock,
	input wire logic nrst,
	input wire logic pin_in,
	input wire logic tx_mode,
	input wire logic tx_bit,
	output logic pin_level,
	output logic bit_done,
	output logic bit_val,
	output logic sync_seen,
	output logic timeout,
	output logic pin_out,
	output logic pin_oe
);
	import sdc_pkg::*;

	// Synchroniser left unreset so the strap level is visible during reset
	logic meta_r;
	logic sync_r;
	logic prev_r;
	logic fall;

	sdc_pin_state_t st_r, st_nxt;
	logic [9:0] cnt_r, cnt_nxt, to_r, to_nxt;
	logic txm_r, txm_nxt, txb_r, txb_nxt;
	logic done_nxt, val_nxt, syn_nxt, tmo_nxt, out_nxt, oe_nxt;

	always_ff @(posedge clock) begin
		meta_r <= pin_in;
		sync_r <= meta_r; // R21
		prev_r <= sync_r;
	end

	assign pin_level = sync_r;
	assign fall = prev_r & ~sync_r; // R1

	always_comb begin
		st_nxt = st_r;
		cnt_nxt = (cnt_r == CNT_MAX) ? cnt_r : cnt_r + 10'h001;
		txm_nxt = txm_r;
		txb_nxt = txb_r;
		done_nxt = 1'b0;
		val_nxt = bit_val;
		syn_nxt = 1'b0;
		// Timeout counter restarts on every falling pin edge, saturates at the limit
		to_nxt = fall ? 10'h000 : ((to_r == TIMEOUT_CYC) ? to_r : to_r + 10'h001);
		tmo_nxt = ~fall && (to_r == TIMEOUT_CYC - 10'h001); // R18
		case (st_r)
			PIN_IDLE: begin
				cnt_nxt = 10'h000;
				if (fall) begin
					st_nxt = PIN_BIT;
					txm_nxt = tx_mode;
					txb_nxt = tx_bit;
				end
			end
			PIN_BIT: begin
				if (cnt_r == SAMPLE_CYC) begin
					done_nxt = 1'b1;
					val_nxt = sync_r; // R19
				end
				if (cnt_r == BIT_CYC - 10'h001) begin // R17
					st_nxt = (~sync_r && ~txm_r) ? PIN_SYNC_LOW : PIN_IDLE;
				end
			end
			PIN_SYNC_LOW: begin
				if (sync_r) begin
					if (cnt_r >= SYNC_MIN_LOW_CYC) begin
						st_nxt = PIN_SYNC_DLY;
						cnt_nxt = 10'h000;
						syn_nxt = 1'b1; // R3
					end else begin
						st_nxt = PIN_IDLE;
					end
				end
			end
			PIN_SYNC_DLY: begin
				if (cnt_r == SYNC_DELAY_CYC - 10'h001) begin
					st_nxt = PIN_SYNC_DRV;
					cnt_nxt = 10'h000;
				end
			end
			PIN_SYNC_DRV: begin
				if (cnt_r == SYNC_PULSE_CYC - 10'h001) begin // R3
					st_nxt = PIN_SYNC_SPD;
				end
			end
			PIN_SYNC_SPD: st_nxt = PIN_IDLE;
			default: st_nxt = PIN_IDLE;
		endcase
		// Drive follows the next count so pin and counter line up
		out_nxt = 1'b0;
		oe_nxt = 1'b0;
		if (st_nxt == PIN_BIT && txm_nxt) begin
			if (~txb_nxt && cnt_nxt < ZERO_LOW_CYC) begin
				oe_nxt = 1'b1; // R20
			end else if (~txb_nxt && cnt_nxt == ZERO_LOW_CYC) begin
				oe_nxt = 1'b1; // R15
				out_nxt = 1'b1;
			end else if (txb_nxt && cnt_nxt == ONE_SPEEDUP_CYC) begin
				oe_nxt = 1'b1; // R15
				out_nxt = 1'b1;
			end
		end else if (st_nxt == PIN_SYNC_DRV) begin
			oe_nxt = 1'b1;
		end else if (st_nxt == PIN_SYNC_SPD) begin
			oe_nxt = 1'b1; // R15
			out_nxt = 1'b1;
		end
		if (!nrst) begin
			st_nxt = PIN_IDLE;
			cnt_nxt = 10'h000;
			to_nxt = 10'h000;
			txm_nxt = 1'b0;
			txb_nxt = 1'b1;
			done_nxt = 1'b0;
			val_nxt = 1'b1;
			syn_nxt = 1'b0;
			tmo_nxt = 1'b0;
			out_nxt = 1'b0;
			oe_nxt = 1'b0; // R21
		end
	end

	always_ff @(posedge clock) begin
		st_r <= st_nxt;
		cnt_r <= cnt_nxt;
		to_r <= to_nxt;
		txm_r <= txm_nxt;
		txb_r <= txb_nxt;
		bit_done <= done_nxt;
		bit_val <= val_nxt;
		sync_seen <= syn_nxt;
		timeout <= tmo_nxt;
		pin_out <= out_nxt;
		pin_oe <= oe_nxt;
	end

endmodule : sdc_pin_engine

`default_nettype wire

/* File: logic/sdc_controller.sv */
/*
 * Single-wire debug controller: command decoder, status and control byte,
 * breakpoint comparator, target access port and CPU mode requests.
 * Assumes the target answers an access with acc_ack within one bit time,
 * and that the CPU reports its halted state on cpu_halted.
 */
// How it works
// (R1) The host starts every bit time with a falling edge on the pin.
// (R2) Commands, addresses and data travel most significant bit first.
// (R3) A long host low pulse gets a timed low reply pulse back.
// (R4) Pin level during reset picks halted start or user program start.
// (R5) Pin high at reset, as with no pod, means normal run.
// (R6) Halted-mode commands are ignored unless the CPU is halted.
// (R7) Halted commands read and write CPU registers, single step, or resume.
// (R8) Non-intrusive commands work at any time without halting the CPU.
// (R9) Non-intrusive commands reach memory and the status and control byte.
// (R10) Controller registers are reachable only through the serial pin.
// (R11) The halt request command also wakes the CPU from stop or wait.
// (R12) One hardware address breakpoint comparator is built in.
// (R13) Oscillator is kept running in stop while the controller is enabled.
// (R14) Watchdog is held off while the CPU is halted.
// (R15) A party releasing a low pin first drives a short high pulse.
// (R16) Serial traffic is accepted at any time, no reset needed.
// (R17) A bit time lasts sixteen controller clocks.
// (R18) After 512 clocks without a host edge the command is dropped.
// (R19) Host bits are sampled ten clocks after the perceived bit start.
// (R20) A zero to the host is low thirteen clocks, then driven high.
// (R21) Pin is synchronised and released whenever not driven.
`timescale 1ns/1ns
`default_nettype none

module sdc_controller
	import sdc_pkg::*;
(
	input wire logic clock,
	input wire logic nrst,
	input wire logic debug_pin_in,
	output logic debug_pin_out,
	output logic debug_pin_oe,
	input wire logic cpu_halted,
	input wire logic fetch_valid,
	input wire logic [15:0] fetch_addr,
	input wire logic acc_ack,
	input wire logic [15:0] acc_rdata,
	output logic acc_req,
	output logic acc_we,
	output logic acc_space,
	output logic [15:0] acc_addr,
	output logic [15:0] acc_wdata,
	output logic halt_req,
	output logic go_req,
	output logic step_req,
	output logic osc_keep_on,
	output logic wdog_hold
);
	import sdc_pkg::*;

	logic pin_level, bit_done, bit_val, sync_seen, timeout;

	sdc_cmd_state_t st_r, st_nxt;
	logic [7:0] cmd_r, cmd_nxt;
	logic [15:0] sh_r, sh_nxt;
	logic [4:0] left_r, left_nxt;
	logic enable_r, enable_nxt, bkpt_en_r, bkpt_en_nxt;
	logic [15:0] bkpt_r, bkpt_nxt;
	logic [15:0] last_r, last_nxt;
	logic req_nxt, we_nxt, space_nxt;
	logic [15:0] addr_nxt, wdata_nxt;
	logic halt_nxt, go_nxt, step_nxt;
	logic [7:0] status;
	logic is_rd_reg, is_wr_reg;

	sdc_pin_engine u_pin (
		.clock(clock),
		.nrst(nrst),
		.pin_in(debug_pin_in),
		.tx_mode(st_r == CS_TX),
		.tx_bit(sh_r[15]), // R2
		.pin_level(pin_level),
		.bit_done(bit_done),
		.bit_val(bit_val),
		.sync_seen(sync_seen),
		.timeout(timeout),
		.pin_out(debug_pin_out),
		.pin_oe(debug_pin_oe)
	);

	assign status = {enable_r, cpu_halted, bkpt_en_r, ST_LOW_ZERO};
	assign is_rd_reg = cmd_r[7:3] == CMD_READ_REG_HI;
	assign is_wr_reg = cmd_r[7:3] == CMD_WRITE_REG_HI;

	////////////////////////////////////////////////////////////////////////////

	always_comb begin
		st_nxt = st_r;
		cmd_nxt = cmd_r;
		sh_nxt = sh_r;
		left_nxt = left_r;
		enable_nxt = enable_r;
		bkpt_en_nxt = bkpt_en_r;
		bkpt_nxt = bkpt_r;
		last_nxt = last_r;
		req_nxt = 1'b0;
		we_nxt = acc_we;
		space_nxt = acc_space;
		addr_nxt = acc_addr;
		wdata_nxt = acc_wdata;
		halt_nxt = 1'b0;
		go_nxt = 1'b0;
		step_nxt = 1'b0;
		// Receive shift, and transmit shift after each sampled bit
		if (bit_done && st_r != CS_ACC) begin
			sh_nxt = {sh_r[14:0], bit_val}; // R2
			left_nxt = left_r - 5'h01;
		end
		case (st_r)
			CS_CMD: begin
				if (bit_done && left_r == 5'h01) begin
					cmd_nxt = {sh_r[6:0], bit_val};
					st_nxt = CS_CMD;
					left_nxt = LEN_BYTE;
					case ({sh_r[6:0], bit_val})
						CMD_BACKGROUND: halt_nxt = enable_r; // R11
						CMD_GO, CMD_TAGGO: go_nxt = cpu_halted; // R6 R7
						CMD_SINGLE_STEP: step_nxt = cpu_halted; // R6 R7
						CMD_READ_STATUS: begin
							st_nxt = CS_TX; // R9
							sh_nxt = {status, 8'h00};
						end
						CMD_WRITE_CONTROL: st_nxt = CS_DATA; // R10
						CMD_READ_BYTE, CMD_READ_BYTE_WS, CMD_WRITE_BYTE, CMD_WRITE_BYTE_WS: begin
							st_nxt = CS_ADDR; // R8
							left_nxt = LEN_WORD;
						end
						CMD_READ_LAST: begin
							st_nxt = CS_ACC;
							req_nxt = 1'b1;
							we_nxt = 1'b0;
							space_nxt = 1'b0;
							addr_nxt = last_r;
						end
						CMD_READ_BKPT: begin
							st_nxt = CS_TX;
							sh_nxt = bkpt_r;
							left_nxt = LEN_WORD;
						end
						CMD_WRITE_BKPT: begin
							st_nxt = CS_DATA;
							left_nxt = LEN_WORD;
						end
						default: begin
							if ({sh_r[6:3], bit_val} != CMD_READ_REG_HI) begin
								st_nxt = CS_CMD;
							end
							if (sh_r[6:2] == CMD_READ_REG_HI && cpu_halted) begin
								st_nxt = CS_ACC; // R7
								req_nxt = 1'b1;
								we_nxt = 1'b0;
								space_nxt = 1'b1;
								addr_nxt = {13'h0000, sh_r[1:0], bit_val};
							end else if (sh_r[6:2] == CMD_WRITE_REG_HI) begin
								// Data is consumed even when running, so it is never a command
								st_nxt = CS_DATA; // R7
								left_nxt = LEN_WORD;
							end
						end
					endcase
				end
			end
			CS_ADDR: begin
				if (bit_done && left_r == 5'h01) begin
					addr_nxt = {sh_r[14:0], bit_val};
					last_nxt = {sh_r[14:0], bit_val};
					space_nxt = 1'b0;
					if (cmd_r == CMD_WRITE_BYTE || cmd_r == CMD_WRITE_BYTE_WS) begin
						st_nxt = CS_DATA;
						left_nxt = LEN_BYTE;
					end else begin
						st_nxt = CS_ACC;
						req_nxt = 1'b1;
						we_nxt = 1'b0;
					end
				end
			end
			CS_DATA: begin
				if (bit_done && left_r == 5'h01) begin
					st_nxt = CS_CMD;
					left_nxt = LEN_BYTE;
					if (cmd_r == CMD_WRITE_CONTROL) begin
						enable_nxt = sh_r[ST_ENABLE_POS - 1];
						bkpt_en_nxt = sh_r[ST_BKPT_EN_POS - 1];
					end else if (cmd_r == CMD_WRITE_BKPT) begin
						bkpt_nxt = {sh_r[14:0], bit_val};
					end else if (!is_wr_reg || cpu_halted) begin // R6
						st_nxt = CS_ACC;
						req_nxt = 1'b1;
						we_nxt = 1'b1;
						space_nxt = is_wr_reg;
						addr_nxt = is_wr_reg ? {13'h0000, cmd_r[2:0]} : acc_addr;
						wdata_nxt = {sh_r[14:0], bit_val};
					end
				end
			end
			CS_ACC: begin
				// Access is already committed, so timeout waits for the answer
				if (acc_ack) begin
					st_nxt = CS_CMD;
					left_nxt = LEN_BYTE;
					if (acc_we) begin
						if (cmd_r == CMD_WRITE_BYTE_WS) begin
							st_nxt = CS_TX;
							sh_nxt = {status, 8'h00};
						end
					end else begin
						st_nxt = CS_TX;
						left_nxt = (cmd_r == CMD_READ_BYTE) ? LEN_BYTE : LEN_WORD;
						if (is_rd_reg) begin
							sh_nxt = acc_rdata;
						end else if (cmd_r == CMD_READ_BYTE) begin
							sh_nxt = {acc_rdata[7:0], 8'h00};
						end else begin
							sh_nxt = {status, acc_rdata[7:0]};
						end
					end
				end
			end
			CS_TX: begin
				if (bit_done && left_r == 5'h01) begin
					st_nxt = CS_CMD;
					left_nxt = LEN_BYTE;
				end
			end
			default: st_nxt = CS_CMD;
		endcase
		if ((timeout || sync_seen) && st_r != CS_ACC) begin
			st_nxt = CS_CMD; // R18 R16
			left_nxt = LEN_BYTE;
			req_nxt = 1'b0;
			halt_nxt = 1'b0;
			go_nxt = 1'b0;
			step_nxt = 1'b0;
		end
		if (enable_r && bkpt_en_r && fetch_valid && fetch_addr == bkpt_r && !cpu_halted) begin
			halt_nxt = 1'b1; // R12
		end
		if (!nrst) begin
			st_nxt = CS_CMD;
			cmd_nxt = 8'h00;
			sh_nxt = 16'h0000;
			left_nxt = LEN_BYTE;
			// Pin low at reset selects halted start, high selects user run
			enable_nxt = ~pin_level; // R4 R5
			halt_nxt = ~pin_level; // R4
			bkpt_en_nxt = BKPT_EN_RST;
			bkpt_nxt = BKPT_ADDR_RST;
			last_nxt = 16'h0000;
			req_nxt = 1'b0;
			we_nxt = 1'b0;
			space_nxt = 1'b0;
			addr_nxt = 16'h0000;
			wdata_nxt = 16'h0000;
			go_nxt = 1'b0;
			step_nxt = 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////

	always_ff @(posedge clock) begin
		st_r <= st_nxt;
		cmd_r <= cmd_nxt;
		sh_r <= sh_nxt;
		left_r <= left_nxt;
		enable_r <= enable_nxt;
		bkpt_en_r <= bkpt_en_nxt;
		bkpt_r <= bkpt_nxt;
		last_r <= last_nxt;
		acc_req <= req_nxt;
		acc_we <= we_nxt;
		acc_space <= space_nxt;
		acc_addr <= addr_nxt;
		acc_wdata <= wdata_nxt;
		halt_req <= halt_nxt;
		go_req <= go_nxt;
		step_req <= step_nxt;
		osc_keep_on <= nrst & enable_nxt; // R13
		wdog_hold <= nrst & cpu_halted; // R14
	end

endmodule : sdc_controller

`default_nettype wire

/* File: tb/sdc_ctrl_asserts.sv */
/* Port checker for the debug controller.
   Bound to sdc_controller; one clock, nrst synchronous active low. */
`timescale 1ns/1ns
`default_nettype none

module sdc_ctrl_chk
	import sdc_pkg::*;
(
	input wire logic clock,
	input wire logic nrst,
	input wire logic debug_pin_in,
	input wire logic debug_pin_out,
	input wire logic debug_pin_oe,
	input wire logic cpu_halted,
	input wire logic fetch_valid,
	input wire logic acc_req,
	input wire logic acc_space,
	input wire logic halt_req,
	input wire logic go_req,
	input wire logic step_req,
	input wire logic osc_keep_on,
	input wire logic wdog_hold
);
	logic [7:0] low_cnt_r;
	logic [7:0] low_cnt_nxt;

	default clocking cb @(posedge clock);
	endclocking

	// Cycles of the running device low drive
	always_comb begin
		low_cnt_nxt = 8'h00;
		if (debug_pin_oe && !debug_pin_out)
			low_cnt_nxt = low_cnt_r + 8'h01;
	end

	always_ff @(posedge clock) begin
		if (!nrst)
			low_cnt_r <= 8'h00;
		else
			low_cnt_r <= low_cnt_nxt;
	end

	////////////////////////////////////////////////////////////////////////
	a_reset_quiet: assert property (!nrst |=> !debug_pin_oe && !acc_req && !go_req)
		else $error("drive or pulse after reset edge");
	a_speedup_one: assert property (disable iff (!nrst) debug_pin_oe && debug_pin_out |=> !debug_pin_oe)
		else $error("high drive longer than one clock");
	a_release_high: assert property (disable iff (!nrst) $fell(debug_pin_oe) |-> $past(debug_pin_out))
		else $error("pin released from low");
	a_low_length: assert property (disable iff (!nrst) debug_pin_oe && debug_pin_out && low_cnt_r != 8'h00
		|-> low_cnt_r == ZERO_LOW_CYC[7:0] || low_cnt_r == SYNC_PULSE_CYC[7:0])
		else $error("low drive of wrong length");
	a_acc_single: assert property (disable iff (!nrst) acc_req |=> !acc_req)
		else $error("access request longer than a pulse");
	a_wdog_follow: assert property (disable iff (!nrst) $past(nrst) |-> wdog_hold == $past(cpu_halted))
		else $error("watchdog hold not following halt");
	a_halted_only: assert property (disable iff (!nrst) step_req || go_req |-> $past(cpu_halted))
		else $error("step or go while running");
	a_halt_enabled: assert property (disable iff (!nrst) halt_req && $past(nrst) |-> osc_keep_on)
		else $error("halt request while disabled");
	a_start_run: assert property ((!nrst && debug_pin_in)[*3] ##1 nrst
		|-> !halt_req ##1 !osc_keep_on)
		else $error("pin high at reset did not start the user program");
	a_start_halt: assert property ((!nrst && !debug_pin_in)[*3] ##1 nrst
		|-> halt_req ##1 osc_keep_on)
		else $error("pin low at reset did not halt");

	c_sync: cover property (low_cnt_r == SYNC_PULSE_CYC[7:0]);
	c_reg: cover property (acc_req && acc_space);
	c_bkpt: cover property (fetch_valid ##1 halt_req);
endmodule : sdc_ctrl_chk

bind sdc_controller sdc_ctrl_chk chk_u (
	.clock(clock), .nrst(nrst), .debug_pin_in(debug_pin_in), .debug_pin_out(debug_pin_out),
	.debug_pin_oe(debug_pin_oe), .cpu_halted(cpu_halted), .fetch_valid(fetch_valid),
	.acc_req(acc_req), .acc_space(acc_space), .halt_req(halt_req), .go_req(go_req),
	.step_req(step_req), .osc_keep_on(osc_keep_on), .wdog_hold(wdog_hold)
);

`default_nettype wire

/* File: tb/sdc_host_pod.sv */
/* Debug pod model: bit cells, reads and the rate request on the pin.
   Assumes the bench resolves the wire with a pull-up and calls the tasks
   one clock edge plus 1 ns into a cycle. */
`timescale 1ns/1ns
`default_nettype none

module sdc_host_pod (
	input wire logic clock,
	input wire logic pin,
	output logic host_oe,
	output logic host_out
);
	logic [15:0] rd_val;
	event done;

	initial begin
		host_oe = 1'b0;
		host_out = 1'b1;
	end

	// Low for n clocks, one clock driven high, then let go
	task automatic pull(input int n);
		host_out = 1'b0;
		host_oe = 1'b1;
		repeat (n) @(posedge clock);
		#1 host_out = 1'b1;
		@(posedge clock);
		#1 host_oe = 1'b0;
	endtask : pull

	// Cells of 24 clocks keep the engine idle between starts
	task automatic tx_bit(input logic b);
		pull(b ? 4 : 16);
		repeat (b ? 19 : 7) @(posedge clock);
		#1;
	endtask : tx_bit

	task automatic send_byte(input logic [7:0] v);
		for (int i = 7; i >= 0; i--)
			tx_bit(v[i]);
	endtask : send_byte

	task automatic send_word(input logic [15:0] v);
		send_byte(v[15:8]);
		send_byte(v[7:0]);
	endtask : send_word

	task automatic rx(input logic [4:0] n);
		rd_val = 16'h0000;
		for (int i = 0; i < n; i++) begin
			pull(2);
			repeat (10) @(posedge clock);
			@(negedge clock);
			rd_val = {rd_val[14:0], pin};
			repeat (10) @(posedge clock);
			#1;
		end
		if (n != 5'h00)
			-> done;
	endtask : rx

	// Long low, then measure the low reply
	task automatic sync_req();
		int n;
		n = 0;
		pull(160);
		for (int i = 0; i < 400; i++) begin
			@(negedge clock);
			if (pin === 1'b0)
				n++;
			else if (n > 0)
				break;
		end
		rd_val = 16'(n);
		-> done;
		@(posedge clock);
		#1;
	endtask : sync_req
endmodule : sdc_host_pod

`default_nettype wire

/* File: tb/sdc_tb.sv */
/* Self-checking bench for the debug controller with a pod model.
   Assumes sdc_pkg and the design files are compiled first. */
`timescale 1ns/1ns
`default_nettype none

module testbench;
	import sdc_pkg::*;
	logic clock, nrst, cpu_halted, fetch_valid, acc_ack, pin, host_oe, host_out;
	logic pin_out, pin_oe, acc_req, acc_we, acc_space, halt_req, go_req, step_req;
	logic osc_keep_on, wdog_hold;
	logic [15:0] fetch_addr, acc_rdata, acc_addr, acc_wdata, rdat, a, w;
	logic [19:0] exp_q[$];
	logic [31:0] lfsr = 32'h96cc5d81;
	localparam logic [7:0] HCMD [3] = '{CMD_SINGLE_STEP, CMD_GO, CMD_TAGGO};
	int failures = 0;
	int total_checks = 0;
	int cyc = 0;

	sdc_controller dut_u (
		.clock(clock), .nrst(nrst), .debug_pin_in(pin), .debug_pin_out(pin_out),
		.debug_pin_oe(pin_oe), .cpu_halted(cpu_halted), .fetch_valid(fetch_valid),
		.fetch_addr(fetch_addr), .acc_ack(acc_ack), .acc_rdata(acc_rdata), .acc_req(acc_req),
		.acc_we(acc_we), .acc_space(acc_space), .acc_addr(acc_addr), .acc_wdata(acc_wdata),
		.halt_req(halt_req), .go_req(go_req), .step_req(step_req),
		.osc_keep_on(osc_keep_on), .wdog_hold(wdog_hold)
	);
	sdc_host_pod pod_u (.clock(clock), .pin(pin), .host_oe(host_oe), .host_out(host_out));

	// Pull-up wins when nobody drives
	assign pin = pin_oe ? pin_out : (host_oe ? host_out : 1'b1);

	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end

	////////////////////////////////////////////////////////////////////////
	function automatic logic [15:0] rnd();
		lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
		return lfsr[15:0];
	endfunction : rnd

	task automatic chk(input string n, input logic [19:0] e, input logic [19:0] g);
		total_checks++;
		if (g !== e) begin
			failures++;
			$display("BAD %s exp %h got %h", n, e, g);
		end
	endtask : chk

	task automatic note(input logic [3:0] k, input logic [15:0] v);
		exp_q.push_back({k, v});
	endtask : note

	task automatic see(input logic [3:0] k, input logic [15:0] v);
		chk("result", exp_q.size() > 0 ? exp_q.pop_front() : 20'hfffff, {k, v});
	endtask : see

	task automatic cmd(input logic [7:0] c, input logic [15:0] ad, input logic has_ad,
		input logic [15:0] wd, input logic [4:0] nw, input logic [4:0] nr);
		pod_u.send_byte(c);
		if (has_ad)
			pod_u.send_word(ad);
		if (nw == LEN_BYTE)
			pod_u.send_byte(wd[7:0]);
		if (nw == LEN_WORD)
			pod_u.send_word(wd);
		repeat (20) @(posedge clock);
		#1;
		pod_u.rx(nr);
	endtask : cmd

	task automatic give_verdict();
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : give_verdict

	////////////////////////////////////////////////////////////////////////
	// Target port: answer one clock late, then scramble the data
	always @(negedge clock) begin
		if (acc_req === 1'b1) begin
			@(posedge clock);
			#1 acc_ack = 1'b1;
			acc_rdata = rdat;
			@(posedge clock);
			#1 acc_ack = 1'b0;
			acc_rdata = ~rdat;
		end
	end

	always @(negedge clock) begin
		if (nrst === 1'b1 && acc_req === 1'b1)
			see(4'h1 + {2'b00, acc_space, acc_we}, acc_addr);
		if (nrst === 1'b1 && acc_req === 1'b1 && acc_we === 1'b1)
			see(4'h6, acc_space ? acc_wdata : {8'h00, acc_wdata[7:0]});
		if (nrst === 1'b1 && halt_req === 1'b1)
			see(4'h8, 16'h0000);
		if (step_req === 1'b1 || go_req === 1'b1)
			see(step_req ? 4'h9 : 4'ha, 16'h0000);
	end

	always @(pod_u.done)
		see(4'h0, pod_u.rd_val);

	always @(posedge clock) begin
		cyc++;
		if (cyc == 60000) begin
			failures++;
			$display("BAD run_time exp end got hang");
			give_verdict();
		end
	end

	////////////////////////////////////////////////////////////////////////
	initial begin
		nrst = 1'b0;
		cpu_halted = 1'b0;
		fetch_valid = 1'b0;
		fetch_addr = 16'h0000;
		acc_ack = 1'b0;
		acc_rdata = 16'h0000;
		rdat = 16'h0000;
		// Three edges, so the strap level has crossed the synchroniser
		repeat (3) @(posedge clock);
		#1 nrst = 1'b1;
		@(posedge clock);
		#1;
		chk("osc_keep_on", 20'h0, {19'h0, osc_keep_on});
		note(4'h0, 16'h0000);
		cmd(CMD_READ_STATUS, 16'h0000, 1'b0, 16'h0000, 5'h00, LEN_BYTE);
		cmd(CMD_WRITE_CONTROL, 16'h0000, 1'b0, 16'h00a0, LEN_BYTE, 5'h00);
		chk("osc_keep_on", 20'h1, {19'h0, osc_keep_on});
		cpu_halted = 1'b1;
		note(4'h0, 16'h00e0);
		cmd(CMD_READ_STATUS, 16'h0000, 1'b0, 16'h0000, 5'h00, LEN_BYTE);
		$display("test status done");
		// Halted set only when halted; a running CPU leaves the pin to the pull-up
		for (int h = 1; h >= 0; h--) begin
			cpu_halted = h[0];
			foreach (HCMD[i]) begin
				if (h == 1)
					note(i == 0 ? 4'h9 : 4'ha, 16'h0000);
				cmd(HCMD[i], 16'h0000, 1'b0, 16'h0000, 5'h00, 5'h00);
			end
			w = rnd();
			rdat = rnd();
			if (h == 1)
				note(4'h4, {13'h0000, w[2:0]});
			if (h == 1)
				note(4'h6, w);
			cmd({CMD_WRITE_REG_HI, w[2:0]}, 16'h0000, 1'b0, w, LEN_WORD, 5'h00);
			if (h == 1)
				note(4'h3, {13'h0000, w[2:0]});
			note(4'h0, h == 1 ? rdat : 16'hffff);
			cmd({CMD_READ_REG_HI, w[2:0]}, 16'h0000, 1'b0, 16'h0000, 5'h00, LEN_WORD);
		end
		$display("test halted done");
		a = rnd();
		rdat = rnd();
		w = rnd();
		note(4'h1, a);
		note(4'h0, {8'h00, rdat[7:0]});
		cmd(CMD_READ_BYTE, a, 1'b1, 16'h0000, 5'h00, LEN_BYTE);
		note(4'h2, a);
		note(4'h6, {8'h00, w[7:0]});
		cmd(CMD_WRITE_BYTE, a, 1'b1, w, LEN_BYTE, 5'h00);
		note(4'h1, a);
		note(4'h0, {8'ha0, rdat[7:0]});
		cmd(CMD_READ_BYTE_WS, a, 1'b1, 16'h0000, 5'h00, LEN_WORD);
		note(4'h1, a);
		note(4'h0, {8'ha0, rdat[7:0]});
		cmd(CMD_READ_LAST, 16'h0000, 1'b0, 16'h0000, 5'h00, LEN_WORD);
		note(4'h2, a);
		note(4'h6, {8'h00, w[7:0]});
		note(4'h0, 16'h00a0);
		cmd(CMD_WRITE_BYTE_WS, a, 1'b1, w, LEN_BYTE, LEN_BYTE);
		$display("test memory done");
		w = rnd();
		cmd(CMD_WRITE_BKPT, 16'h0000, 1'b0, w, LEN_WORD, 5'h00);
		note(4'h0, w);
		cmd(CMD_READ_BKPT, 16'h0000, 1'b0, 16'h0000, 5'h00, LEN_WORD);
		fetch_valid = 1'b1;
		fetch_addr = w ^ 16'h0001;
		note(4'h8, 16'h0000);
		@(posedge clock);
		#1 fetch_addr = w;
		@(posedge clock);
		#1 fetch_valid = 1'b0;
		note(4'h8, 16'h0000);
		cmd(CMD_BACKGROUND, 16'h0000, 1'b0, 16'h0000, 5'h00, 5'h00);
		$display("test halt done");
		pod_u.send_byte(CMD_WRITE_BYTE);
		repeat (600) @(posedge clock);
		#1;
		note(4'h0, 16'h00a0);
		cmd(CMD_READ_STATUS, 16'h0000, 1'b0, 16'h0000, 5'h00, LEN_BYTE);
		note(4'h0, {6'h00, SYNC_PULSE_CYC});
		pod_u.sync_req();
		$display("test timeout_sync done");
		note(4'h8, 16'h0000);
		fork
			pod_u.pull(8);
			begin
				@(posedge clock);
				#1 nrst = 1'b0;
				repeat (4) @(posedge clock);
				#1 nrst = 1'b1;
			end
		join
		chk("osc_keep_on", 20'h1, {19'h0, osc_keep_on});
		repeat (30) @(posedge clock);
		chk("queue", 20'h0, 20'(exp_q.size()));
		$display("test reset_low done");
		give_verdict();
	end
endmodule : testbench

`default_nettype wire
